// ---- pkg/ncs_pkg.sv ----
// Package of constants and types for the NCO channel select block
package ncs_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int NCS_WORD_W   = 48;
    localparam int NCS_ADDR_W   = 12;
    localparam int NCS_DATA_W   = 8;
    localparam int NCS_CHAN_W   = 4;
    localparam int NCS_NUM_CHAN = 16;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] NCS_PIN_FUNC_LOW_OFS  = 12'h040;
    localparam logic [11:0] NCS_PIN_FUNC_HIGH_OFS = 12'h041;
    localparam logic [11:0] NCS_SYNC_CTRL_OFS     = 12'h300;
    localparam logic [11:0] NCS_CHAN0_SEL_OFS     = 12'h314;
    localparam logic [11:0] NCS_CHAN1_SEL_OFS     = 12'h334;
    localparam logic [11:0] NCS_CHAN2_SEL_OFS     = 12'h354;
    localparam logic [11:0] NCS_CHAN3_SEL_OFS     = 12'h374;
    localparam logic [11:0] NCS_STATUS_OFS        = 12'h315;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] NCS_PIN_FUNC_LOW_RST  = 8'h00;
    localparam logic [7:0] NCS_PIN_FUNC_HIGH_RST = 8'h00;
    localparam logic [7:0] NCS_SYNC_CTRL_RST     = 8'h00;
    localparam logic [7:0] NCS_CHAN_SEL_RST      = 8'h00;

    // ----------------------------------------------------------------
    // Field positions and codes
    // ----------------------------------------------------------------
    localparam int NCS_SOFT_RST_BIT   = 4;
    localparam int NCS_SYNC_EN_LSB    = 0;
    localparam int NCS_SEL_MODE_LSB   = 4;
    localparam int NCS_PIN1_LOW_LSB   = 0;
    localparam int NCS_PIN2_LOW_LSB   = 3;
    localparam int NCS_PIN1_HIGH_LSB  = 0;
    localparam int NCS_PIN2_HIGH_LSB  = 4;
    localparam logic [2:0] NCS_PIN_LOW_SEL_CODE  = 3'h6;
    localparam logic [3:0] NCS_PIN_HIGH_SEL_CODE = 4'h0;

    typedef enum logic [3:0] {
        NCS_MODE_REG      = 4'h0,
        NCS_MODE_LVL_A    = 4'h1,
        NCS_MODE_LVL_B    = 4'h2,
        NCS_MODE_LVL_C    = 4'h3,
        NCS_MODE_LVL_D    = 4'h4,
        NCS_MODE_LVL_E    = 4'h5,
        NCS_MODE_LVL_F    = 4'h6,
        NCS_MODE_EDGE_P1  = 4'h8,
        NCS_MODE_EDGE_P2  = 4'h9,
        NCS_MODE_EDGE_P3  = 4'hA,
        NCS_MODE_EDGE_P4  = 4'hB
    } ncs_sel_mode_t;

endpackage : ncs_pkg

// ---- pkg/ncs_nco_if.sv ----
// Interface between channel select control and the phase accumulator
interface ncs_nco_if;
    import ncs_pkg::*;
    logic [NCS_WORD_W-1:0] frequency_tuning_word;
    logic [NCS_WORD_W-1:0] num;
    logic [NCS_WORD_W-1:0] den;
    logic [NCS_WORD_W-1:0] phase_offset_word;
    logic                  sync;
    logic [NCS_WORD_W-1:0] phase;
    logic                  mod_active;

    modport ctrl (output frequency_tuning_word, output num, output den, output phase_offset_word, output sync,
                  input phase, input mod_active);
    modport acc  (input frequency_tuning_word, input num, input den, input phase_offset_word, input sync,
                  output phase, output mod_active);
endinterface : ncs_nco_if

// ---- hdl/ncs_phase_acc.sv ----
// Phase accumulator with programmable modulus and phase offset
module ncs_phase_acc
    import ncs_pkg::*;
(
    input  wire logic clk,
    input  wire logic arst_n,
    ncs_nco_if.acc    nco
);

    logic [NCS_WORD_W-1:0] acc_reg;
    logic [NCS_WORD_W-1:0] acc_next;
    logic [NCS_WORD_W:0]   frac_reg;
    logic [NCS_WORD_W:0]   frac_next;
    logic [NCS_WORD_W-1:0] phase_reg;
    logic [NCS_WORD_W-1:0] phase_next;
    logic                  mod_reg;
    logic                  mod_next;
    logic                  carry;
    logic [NCS_WORD_W:0]   frac_sum;

    // ----------------------------------------------------------------
    // Accumulator update
    // ----------------------------------------------------------------
    always_comb begin
        mod_next = (nco.num != '0);
        frac_sum = frac_reg + {1'b0, nco.num};
        carry    = 1'b0;
        frac_next = frac_sum;
        if (!mod_next) begin
            frac_next = '0;
        end else if (frac_sum >= {1'b0, nco.den}) begin
            // Fraction wraps modulo the denominator
            frac_next = frac_sum - {1'b0, nco.den};
            carry     = 1'b1;
        end
        // Twos complement add; the wrap of 48 bits is the phase wrap
        acc_next   = acc_reg + nco.frequency_tuning_word + {{(NCS_WORD_W-1){1'b0}}, carry};
        phase_next = acc_reg + nco.phase_offset_word;
        if (nco.sync) begin
            acc_next  = '0;
            frac_next = '0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_reg   <= '0;
            frac_reg  <= '0;
            phase_reg <= '0;
            mod_reg   <= 1'b0;
        end else begin
            acc_reg   <= acc_next;
            frac_reg  <= frac_next;
            phase_reg <= phase_next;
            mod_reg   <= mod_next;
        end
    end

    assign nco.phase      = phase_reg;
    assign nco.mod_active = mod_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    acc_sync_zero_a: assert property (@(posedge clk) disable iff (!arst_n)
        nco.sync |=> acc_reg == '0)
        else $error("accumulator not cleared by sync");

    acc_coherent_step_a: assert property (@(posedge clk) disable iff (!arst_n)
        (!nco.sync && nco.num == '0) |=> acc_reg == $past(acc_reg) + $past(nco.frequency_tuning_word))
        else $error("coherent step differs from tuning word");

    phase_offset_sum_a: assert property (@(posedge clk) disable iff (!arst_n)
        1'b1 |=> phase_reg == $past(acc_reg) + $past(nco.phase_offset_word))
        else $error("output phase not accumulator plus offset");

    frac_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
        nco.num == '0 |=> frac_reg == '0 && !mod_reg)
        else $error("modulus logic active with zero numerator");

endmodule : ncs_phase_acc

// ---- hdl/ncs_chan_select.sv ----
// NCO channel select: register access, shadow tuning bank, selectors
// ----------------------------------------------------------------
// Overview of operation
// - Nonzero numerator enables modulus; zero disables it
// - Tuning word is 48-bit twos complement
// - Denominator word is 48-bit unsigned modulus
// - Tuning and offset words writable any time
// - 48-bit phase offset added per oscillator
// - Sixteen shadow tuning channels kept
// - Exactly one channel active at any time
// - Selector has level, edge and register modes
// - Modes 0x1-0x6: pin levels give channel
// - Unconfigured select pins read as low
// - Modes 0x8-0x9: rising edges advance counter; 0xA-0xB hold it
// - Low four bits set counter wrap point
// - Sync or soft reset clears counter
// - Register mode takes channel from register
// - Switching channel leaves accumulated phase alone
// - Mode zero selects register map control
// - Accumulator resets to zero, advances each cycle
// - Soft reset bit resets all accumulators
// ----------------------------------------------------------------
module ncs_chan_select
    import ncs_pkg::*;
#(
    parameter int         NUM_CHAN = NCS_NUM_CHAN,
    parameter int         DDC_IDX  = 0
)
(
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    input  wire logic [NCS_ADDR_W-1:0] reg_addr,
    input  wire logic [NCS_DATA_W-1:0] reg_wdata,
    output      logic [NCS_DATA_W-1:0] reg_rdata,
    input  wire logic                  chan_wr,
    input  wire logic [NCS_CHAN_W-1:0] chan_idx,
    input  wire logic [NCS_WORD_W-1:0] chan_ftw,
    input  wire logic [NCS_WORD_W-1:0] chan_pow,
    input  wire logic [NCS_WORD_W-1:0] modulus_numerator_word,
    input  wire logic [NCS_WORD_W-1:0] modulus_denominator_word,
    input  wire logic                  sysref,
    input  wire logic                  select_pin_one,
    input  wire logic                  select_pin_two,
    output      logic [NCS_WORD_W-1:0] nco_phase,
    output      logic [NCS_CHAN_W-1:0] active_chan,
    output      logic                  modulus_active
);

    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    // A pin feeds the selector only when both function fields pick it
    function automatic logic pin_enabled(input logic [2:0] low_fld,
                                         input logic [3:0] high_fld);
        pin_enabled = (low_fld == NCS_PIN_LOW_SEL_CODE) &&
                      (high_fld == NCS_PIN_HIGH_SEL_CODE);
    endfunction : pin_enabled

    function automatic logic [11:0] sel_ofs(input int idx);
        unique case (idx)
            0:       sel_ofs = NCS_CHAN0_SEL_OFS;
            1:       sel_ofs = NCS_CHAN1_SEL_OFS;
            2:       sel_ofs = NCS_CHAN2_SEL_OFS;
            default: sel_ofs = NCS_CHAN3_SEL_OFS;
        endcase
    endfunction : sel_ofs

    localparam logic [11:0] SEL_OFS = sel_ofs(DDC_IDX);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] pin_func_low_reg;
    logic [7:0] pin_func_low_next;
    logic [7:0] pin_func_high_reg;
    logic [7:0] pin_func_high_next;
    logic [7:0] sync_ctrl_reg;
    logic [7:0] sync_ctrl_next;
    logic [7:0] sel_ctrl_reg;
    logic [7:0] sel_ctrl_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [NCS_CHAN_W-1:0] active_chan_reg;
    logic [NCS_CHAN_W-1:0] active_chan_next;

    // Declared early so the status read can see the modulus flag
    ncs_nco_if nco ();

    always_comb begin
        pin_func_low_next  = pin_func_low_reg;
        pin_func_high_next = pin_func_high_reg;
        sync_ctrl_next     = sync_ctrl_reg;
        sel_ctrl_next      = sel_ctrl_reg;
        rdata_next         = rdata_reg;
        if (reg_wr) begin
            unique case (reg_addr)
                NCS_PIN_FUNC_LOW_OFS:  pin_func_low_next  = reg_wdata;
                NCS_PIN_FUNC_HIGH_OFS: pin_func_high_next = reg_wdata;
                NCS_SYNC_CTRL_OFS:     sync_ctrl_next     = reg_wdata;
                SEL_OFS:               sel_ctrl_next      = reg_wdata;
                default: ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                NCS_PIN_FUNC_LOW_OFS:  rdata_next = pin_func_low_reg;
                NCS_PIN_FUNC_HIGH_OFS: rdata_next = pin_func_high_reg;
                NCS_SYNC_CTRL_OFS:     rdata_next = sync_ctrl_reg;
                SEL_OFS:               rdata_next = sel_ctrl_reg;
                NCS_STATUS_OFS:        rdata_next = {3'h0, nco.mod_active, active_chan_reg};
                default:               rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_func_low_reg  <= NCS_PIN_FUNC_LOW_RST;
            pin_func_high_reg <= NCS_PIN_FUNC_HIGH_RST;
            sync_ctrl_reg     <= NCS_SYNC_CTRL_RST;
            sel_ctrl_reg      <= NCS_CHAN_SEL_RST;
            rdata_reg         <= 8'h00;
        end else begin
            pin_func_low_reg  <= pin_func_low_next;
            pin_func_high_reg <= pin_func_high_next;
            sync_ctrl_reg     <= sync_ctrl_next;
            sel_ctrl_reg      <= sel_ctrl_next;
            rdata_reg         <= rdata_next;
        end
    end

    // ----------------------------------------------------------------
    // Synchronisation event
    // ----------------------------------------------------------------
    logic soft_rst;
    logic sync_evt;

    // Accumulators stay cleared while the soft reset bit is high
    assign soft_rst = sync_ctrl_reg[NCS_SOFT_RST_BIT];
    assign sync_evt = soft_rst ||
                      (sysref && (sync_ctrl_reg[NCS_SYNC_EN_LSB +: 2] != 2'h0));

    // ----------------------------------------------------------------
    // Shadow tuning bank
    // ----------------------------------------------------------------
    logic [NCS_WORD_W-1:0] ftw_mem [NUM_CHAN];
    logic [NCS_WORD_W-1:0] pow_mem [NUM_CHAN];

    // Writes land at any time; the accumulator just picks them up
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                ftw_mem[i] <= '0;
                pow_mem[i] <= '0;
            end
        end else if (chan_wr) begin
            ftw_mem[chan_idx] <= chan_ftw;
            pow_mem[chan_idx] <= chan_pow;
        end
    end

    // ----------------------------------------------------------------
    // Channel selector
    // ----------------------------------------------------------------
    logic                  pin1_en;
    logic                  pin2_en;
    logic                  pin1_lvl;
    logic                  pin2_lvl;
    logic                  pin1_prev_reg;
    logic                  pin2_prev_reg;
    logic                  edge_hit;
    logic [3:0]            sel_mode;
    logic [3:0]            wrap_pt;
    logic [NCS_CHAN_W-1:0] edge_cnt_reg;
    logic [NCS_CHAN_W-1:0] edge_cnt_next;
    logic                  edge_mode;

    assign pin1_en  = pin_enabled(pin_func_low_reg[NCS_PIN1_LOW_LSB +: 3],
                                  pin_func_high_reg[NCS_PIN1_HIGH_LSB +: 4]);
    assign pin2_en  = pin_enabled(pin_func_low_reg[NCS_PIN2_LOW_LSB +: 3],
                                  pin_func_high_reg[NCS_PIN2_HIGH_LSB +: 4]);
    assign pin1_lvl = select_pin_one && pin1_en;
    assign pin2_lvl = select_pin_two && pin2_en;
    assign sel_mode = sel_ctrl_reg[NCS_SEL_MODE_LSB +: 4];
    assign wrap_pt  = sel_ctrl_reg[3:0];
    assign edge_mode = (sel_mode >= NCS_MODE_EDGE_P1) && (sel_mode <= NCS_MODE_EDGE_P4);

    always_comb begin
        // Only two select pins exist here; the other edge codes see none
        unique case (sel_mode)
            NCS_MODE_EDGE_P1: edge_hit = pin1_lvl && !pin1_prev_reg;
            NCS_MODE_EDGE_P2: edge_hit = pin2_lvl && !pin2_prev_reg;
            default:          edge_hit = 1'b0;
        endcase
        edge_cnt_next = edge_cnt_reg;
        if (sync_evt) begin
            edge_cnt_next = '0;
        end else if (edge_mode && edge_hit) begin
            // A wrap point lowered below the count also sends it home
            if (edge_cnt_reg >= wrap_pt) begin
                edge_cnt_next = '0;
            end else begin
                edge_cnt_next = edge_cnt_reg + 4'h1;
            end
        end
    end

    always_comb begin
        // One channel number is produced in every mode
        unique case (sel_mode)
            NCS_MODE_REG:     active_chan_next = sel_ctrl_reg[3:0];
            NCS_MODE_LVL_A:   active_chan_next = {2'h0, pin2_lvl, pin1_lvl};
            NCS_MODE_LVL_B:   active_chan_next = {2'h0, pin1_lvl, pin2_lvl};
            NCS_MODE_LVL_C:   active_chan_next = {3'h0, pin1_lvl};
            NCS_MODE_LVL_D:   active_chan_next = {3'h0, pin2_lvl};
            NCS_MODE_LVL_E:   active_chan_next = {pin2_lvl, pin1_lvl, 2'h0};
            NCS_MODE_LVL_F:   active_chan_next = {pin1_lvl, pin2_lvl, 2'h0};
            NCS_MODE_EDGE_P1,
            NCS_MODE_EDGE_P2,
            NCS_MODE_EDGE_P3,
            NCS_MODE_EDGE_P4: active_chan_next = edge_cnt_reg;
            default:          active_chan_next = active_chan_reg;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin1_prev_reg   <= 1'b0;
            pin2_prev_reg   <= 1'b0;
            edge_cnt_reg    <= '0;
            active_chan_reg <= '0;
        end else begin
            pin1_prev_reg   <= pin1_lvl;
            pin2_prev_reg   <= pin2_lvl;
            edge_cnt_reg    <= edge_cnt_next;
            active_chan_reg <= active_chan_next;
        end
    end

    // ----------------------------------------------------------------
    // Phase accumulator
    // ----------------------------------------------------------------
    // Channel change swaps the increment and phase offset, never the accumulator
    assign nco.frequency_tuning_word  = ftw_mem[active_chan_reg];
    assign nco.phase_offset_word  = pow_mem[active_chan_reg];
    assign nco.num  = modulus_numerator_word;
    assign nco.den  = modulus_denominator_word;
    assign nco.sync = sync_evt;

    ncs_phase_acc u_acc (
        .clk    (clk),
        .arst_n (arst_n),
        .nco    (nco.acc)
    );

    assign reg_rdata      = rdata_reg;
    assign active_chan    = active_chan_reg;
    assign nco_phase      = nco.phase;
    assign modulus_active = nco.mod_active;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    edge_cnt_clear_a: assert property (@(posedge clk) disable iff (!arst_n)
        sync_evt |=> edge_cnt_reg == '0)
        else $error("edge counter not cleared by sync");

    edge_cnt_wrap_a: assert property (@(posedge clk) disable iff (!arst_n)
        (!sync_evt && edge_mode && edge_hit && edge_cnt_reg >= wrap_pt)
        |=> edge_cnt_reg == '0)
        else $error("edge counter did not wrap");

    edge_cnt_step_a: assert property (@(posedge clk) disable iff (!arst_n)
        (!sync_evt && edge_mode && edge_hit && edge_cnt_reg < wrap_pt)
        |=> edge_cnt_reg == $past(edge_cnt_reg) + 4'h1)
        else $error("edge counter did not advance");

    reg_mode_chan_a: assert property (@(posedge clk) disable iff (!arst_n)
        (sel_mode == NCS_MODE_REG)
        |=> active_chan_reg == $past(sel_ctrl_reg[3:0]))
        else $error("register mode channel mismatch");

    pin_tied_low_a: assert property (@(posedge clk) disable iff (!arst_n)
        (sel_mode == NCS_MODE_LVL_A && !pin1_en && !pin2_en)
        |=> active_chan_reg == '0)
        else $error("unconfigured pin reached selector");

    level_mode_a: assert property (@(posedge clk) disable iff (!arst_n)
        (sel_mode == NCS_MODE_LVL_A)
        |=> active_chan_reg == {2'h0, $past(pin2_lvl), $past(pin1_lvl)})
        else $error("level mode channel mismatch");

    soft_rst_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        soft_rst [*3] |-> nco_phase == $past(nco.phase_offset_word))
        else $error("phase not held at offset in soft reset");

endmodule : ncs_chan_select

// ---- verif/ncs_host_model.sv ----
// Host model: register port, shadow loads, modulus words, sync pulse and select pins
module ncs_host_model
    import ncs_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic [NCS_DATA_W-1:0] reg_rdata,
    output      logic                  reg_wr,
    output      logic                  reg_rd,
    output      logic [NCS_ADDR_W-1:0] reg_addr,
    output      logic [NCS_DATA_W-1:0] reg_wdata,
    output      logic                  chan_wr,
    output      logic [NCS_CHAN_W-1:0] chan_idx,
    output      logic [NCS_WORD_W-1:0] chan_ftw,
    output      logic [NCS_WORD_W-1:0] chan_pow,
    output      logic [NCS_WORD_W-1:0] modulus_numerator_word,
    output      logic [NCS_WORD_W-1:0] modulus_denominator_word,
    output      logic                  sysref,
    output      logic                  select_pin_one,
    output      logic                  select_pin_two
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {reg_wr, reg_rd, chan_wr, sysref, select_pin_one, select_pin_two} = '0;
        {reg_addr, reg_wdata, chan_idx, chan_ftw, chan_pow} = '0;
        {modulus_numerator_word, modulus_denominator_word} = '0;
    end
    // ----------------------------------------------------------------
    // Bus cycles: idle lines show inverted data; chan_idx keeps its last value
    // ----------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(negedge clk);
        {reg_addr, reg_wdata, reg_wr} = {a, v, 1'b1};
        @(negedge clk);
        {reg_addr, reg_wdata, reg_wr} = {~a, ~v, 1'b0};
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [7:0] v);
        @(negedge clk);
        {reg_addr, reg_rd} = {a, 1'b1};
        @(negedge clk);
        {reg_addr, reg_rd} = {~a, 1'b0};
        @(negedge clk);
        v = reg_rdata;
    endtask : rd
    task automatic ld(input logic [3:0] i, input logic [47:0] f, p);
        @(negedge clk);
        {chan_idx, chan_ftw, chan_pow, chan_wr} = {i, f, p, 1'b1};
        @(negedge clk);
        {chan_ftw, chan_pow, chan_wr} = {~f, ~p, 1'b0};
    endtask : ld
    // Numerator kept reduced and below 2^47, zero for coherent use; soft reset follows
    task automatic words(input logic [47:0] n, dn);
        @(negedge clk);
        {modulus_numerator_word, modulus_denominator_word} = {n, dn};
        wr(NCS_SYNC_CTRL_OFS, 8'h10);
    endtask : words
    task automatic sync_pulse;
        @(negedge clk);
        sysref = 1'b1;
        @(negedge clk);
        sysref = 1'b0;
    endtask : sync_pulse
    task automatic pins(input logic p, q);
        @(negedge clk);
        {select_pin_one, select_pin_two} = {p, q};
    endtask : pins
endmodule : ncs_host_model

// ---- verif/ncs_chan_select_tb.sv ----
// Self-checking testbench for the NCO channel select block
module ncs_chan_select_tb;
    import ncs_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    wire logic reg_wr, reg_rd, chan_wr, sysref, select_pin_one, select_pin_two, modulus_active;
    wire logic [11:0] reg_addr;
    wire logic [7:0]  reg_wdata, reg_rdata;
    wire logic [3:0]  chan_idx, active_chan;
    wire logic [47:0] chan_ftw, chan_pow, modulus_numerator_word, modulus_denominator_word;
    wire logic [47:0] nco_phase;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    int seed = 59818;
    logic [7:0]  d;
    logic [3:0]  ch;
    logic [47:0] f0, f1, pw, p0;
    logic        hit, p, q;
    logic [11:0] ofs [6] = '{12'h040, 12'h041, 12'h300, 12'h314, 12'h315, 12'h123};

    always #50 clk = ~clk;

    ncs_chan_select u_dut (.clk, .arst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .chan_wr, .chan_idx, .chan_ftw, .chan_pow, .modulus_numerator_word,
        .modulus_denominator_word, .sysref, .select_pin_one, .select_pin_two, .nco_phase,
        .active_chan, .modulus_active);
    ncs_host_model u_host (.clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .chan_wr,
        .chan_idx, .chan_ftw, .chan_pow, .modulus_numerator_word, .modulus_denominator_word,
        .sysref, .select_pin_one, .select_pin_two);

    task automatic chk(input logic [47:0] g, e);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("mismatches=%0d checked=%0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop
    // Phase advance over n cycles
    task automatic adv(input int n, input logic [47:0] e);
        p0 = nco_phase;
        repeat (n) @(negedge clk);
        chk(nco_phase - p0, e);
    endtask : adv
    task automatic settle;
        repeat (3) @(negedge clk);
    endtask : settle
    function automatic logic [3:0] lvl(input logic [3:0] m, input logic a, b);
        case (m)
            4'h1: lvl = {2'b00, b, a};
            4'h2: lvl = {2'b00, a, b};
            4'h3: lvl = {3'b000, a};
            4'h4: lvl = {3'b000, b};
            4'h5: lvl = {b, a, 2'b00};
            4'h6: lvl = {a, b, 2'b00};
            default: lvl = 4'h0;
        endcase
    endfunction : lvl

    // A hang is cut short well past the expected run of a few hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            report_and_stop;
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk) arst_n = 1'b1;
        foreach (ofs[i]) begin
            u_host.rd(ofs[i], d);
            chk(d, 0);
        end
        repeat (6) begin
            ch = 4'($random(seed));
            u_host.pins(1'($random(seed)), 1'($random(seed)));
            u_host.wr(NCS_CHAN0_SEL_OFS, {4'h0, ch});
            settle;
            chk(active_chan, ch);
            u_host.rd(NCS_STATUS_OFS, d);
            chk(d, {4'h0, ch});
        end
        f0 = {$random(seed), $random(seed)};
        f1 = {$random(seed), $random(seed)};
        pw = {$random(seed), $random(seed)};
        u_host.ld(4'h5, f0, pw);
        u_host.ld(4'h6, f1, pw);
        u_host.wr(NCS_CHAN0_SEL_OFS, 8'h05);
        u_host.words(48'h0, 48'h1);
        settle;
        chk(nco_phase, pw);
        u_host.wr(NCS_SYNC_CTRL_OFS, 8'h00);
        settle;
        chk(modulus_active, 0);
        adv(1, f0);
        adv(5, 48'd5 * f0);
        p0 = nco_phase;
        u_host.wr(NCS_CHAN0_SEL_OFS, 8'h06);
        repeat (4) @(negedge clk);
        hit = 1'b0;
        for (int a = 0; a <= 6; a++) if (nco_phase - p0 == 48'(a) * f0 + 48'(6 - a) * f1) hit = 1;
        chk(hit, 1);
        adv(1, f1);
        f1 = {$random(seed), $random(seed)};
        u_host.ld(4'h6, f1, pw);
        settle;
        adv(1, f1);
        u_host.words(48'h1, 48'h3);
        u_host.wr(NCS_SYNC_CTRL_OFS, 8'h00);
        settle;
        chk(modulus_active, 1);
        adv(3, 48'd3 * f1 + 48'd1);
        adv(6, 48'd6 * f1 + 48'd2);
        u_host.words(48'h0, 48'h1);
        u_host.wr(NCS_SYNC_CTRL_OFS, 8'h00);
        u_host.wr(NCS_PIN_FUNC_LOW_OFS, 8'h36);
        u_host.wr(NCS_PIN_FUNC_HIGH_OFS, 8'h00);
        for (int m = 1; m <= 6; m++) begin
            u_host.wr(NCS_CHAN0_SEL_OFS, {4'(m), 4'h0});
            repeat (3) begin
                {p, q} = 2'($random(seed));
                u_host.pins(p, q);
                settle;
                chk(active_chan, lvl(4'(m), p, q));
            end
        end
        u_host.wr(NCS_PIN_FUNC_LOW_OFS, 8'h06);
        u_host.wr(NCS_CHAN0_SEL_OFS, 8'h10);
        u_host.pins(1'b1, 1'b1);
        settle;
        chk(active_chan, 4'h1);
        u_host.wr(NCS_PIN_FUNC_LOW_OFS, 8'h36);
        u_host.pins(1'b0, 1'b0);
        u_host.wr(NCS_CHAN0_SEL_OFS, 8'h82);
        for (int k = 1; k <= 5; k++) begin
            u_host.pins(1'b1, 1'($random(seed)));
            u_host.pins(1'b0, 1'($random(seed)));
            settle;
            chk(active_chan, 4'(k % 3));
        end
        u_host.wr(NCS_SYNC_CTRL_OFS, 8'h01);
        u_host.sync_pulse;
        settle;
        chk(active_chan, 4'h0);
        u_host.pins(1'b1, 1'b0);
        u_host.pins(1'b0, 1'b0);
        u_host.wr(NCS_SYNC_CTRL_OFS, 8'h10);
        u_host.wr(NCS_SYNC_CTRL_OFS, 8'h00);
        settle;
        chk(active_chan, 4'h0);
        u_host.wr(NCS_CHAN0_SEL_OFS, 8'h93);
        u_host.pins(1'b0, 1'b1);
        u_host.pins(1'b0, 1'b0);
        settle;
        chk(active_chan, 4'h1);
        report_and_stop;
    end
endmodule : ncs_chan_select_tb
